// >>> hw/pin_edge_sync.sv
// Purpose: Two-stage synchroniser with edge detection for a pin
// Assumes: Single clock, synchronous active-high reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pin_edge_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pin side
  input  wire logic [W-1:0] pin_in,
  // Synchronised side
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [1:0]   arm_r;
  logic         armed;

  // Edges are held off until all stages carry the pin, so a pulled-up pin gives no false edge
  assign armed = (arm_r == 2'h3);

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      arm_r  <= 2'h0;
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      if (!armed) begin
        arm_r <= arm_r + 2'h1;
      end
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r & {W{armed}};
  assign fall  = ~sync_r & prev_r & {W{armed}};
endmodule

// >>> hw/pin_mux_pkg.sv
// Purpose: Shared constants for the port function multiplexer
// Assumes: Three roles per pin, encoded in two selector bits
// Notes:   Role code 3 is treated as primary
package pin_mux_pkg;
  localparam logic [1:0] ROLE_PRIMARY   = 2'h0;
  localparam logic [1:0] ROLE_SECONDARY = 2'h1;
  localparam logic [1:0] ROLE_TERTIARY  = 2'h2;
  localparam int unsigned SEL_W         = 2;
  localparam int unsigned P2_W          = 3;
  localparam int unsigned P4_W          = 4;
  localparam int unsigned P8_W          = 8;
  localparam logic [7:0] EXI_EN_RESET   = 8'h00;
  localparam logic [7:0] EXI_EDGE_RESET = 8'h00;
  localparam logic [1:0] SYNC_RESET     = 2'h0;
endpackage

// >>> hw/port_function_multiplexer.sv
// Purpose: Per-pin role selection between port, peripheral and analog functions
// Assumes: One 25 MHz clock; pins arrive asynchronously and are synchronised
// Notes:   Outputs are registered, so pin effects lag the selectors by one cycle
`timescale 1ns/1ps
// Overview of operation
// - Secondary or tertiary role cuts the port from a pin only where that role has a function routed to it.
// - Pin input levels stay readable in port data even in peripheral roles.
// - While the reset pin is low the system stays in reset.
// - When the reset pin returns high the system leaves reset.
// - Both edges of the non-maskable input raise a request.
// - Each external interrupt input has its own enable and edge choice.
// - External interrupt inputs 0 to 7 sit on port 8 bits 0 to 7.
// - Port 2 bit 0 secondary role drives the slow clock.
// - Port 2 bit 1 secondary role drives the fast clock.
// - Port 2 bits 0 to 2 primary role drive port data ORed with the LED outputs where LED_MODE is set.
// - Serial channel 0 tertiary on port 4 bits 0-2 or port 8 bits 0-2.
// - Serial channel 1 tertiary on port 8 bits 4-6, secondary on port 4 0-2.
// - Serial clock pins drive when generating, sample when receiving.
// - UART transmit on port 8 bit 7, receive on bit 6, secondary.
// - I2C data on port 8 bit 0 is open drain, low or released.
// - I2C clock on port 8 bit 1 is open drain; board adds pull-ups.
// - Analog channels 0-2 on port 4 bits 0-2, channel 3 on bit 3.
module port_function_multiplexer #(
  parameter bit HAS_CH3 = 1'b1
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RESET,
  // Reset pin and system reset
  input  wire logic       RESET_PIN_N,
  output logic            SYS_RESET,
  // Role selectors, two bits per pin
  input  wire logic [5:0] P2_ROLE_SEL,
  input  wire logic [7:0] P4_ROLE_SEL,
  input  wire logic [15:0] P8_ROLE_SEL,
  // Port data registers (software side)
  input  wire logic [2:0] P2_PORT_OUT,
  input  wire logic [3:0] P4_PORT_OUT,
  input  wire logic [3:0] P4_PORT_OE,
  input  wire logic [7:0] P8_PORT_OUT,
  input  wire logic [7:0] P8_PORT_OE,
  output logic      [3:0] P4_PORT_DATA_REG,
  output logic      [7:0] P8_PORT_DATA_REG,
  // LED and clock sources
  input  wire logic [2:0] LED_DRIVE_OUTPUTS,
  input  wire logic [2:0] LED_MODE,
  input  wire logic       SLOW_CLOCK_OUT,
  input  wire logic       FAST_CLOCK_OUT,
  // Serial channel 0
  input  wire logic       SERIAL0_PIN_SET,
  input  wire logic       SERIAL0_DATA_OUT,
  input  wire logic       SERIAL0_CLOCK_OUT,
  input  wire logic       SERIAL0_CLOCK_MASTER,
  output logic            SERIAL0_DATA_IN,
  output logic            SERIAL0_CLOCK_IN,
  // Serial channel 1
  input  wire logic       SERIAL1_DATA_OUT,
  input  wire logic       SERIAL1_CLOCK_OUT,
  input  wire logic       SERIAL1_CLOCK_MASTER,
  output logic            SERIAL1_DATA_IN,
  output logic            SERIAL1_CLOCK_IN,
  // UART
  input  wire logic       UART_TRANSMIT_LINE,
  output logic            UART_RECEIVE_LINE,
  // I2C
  input  wire logic       I2C_SDA_PULL_LOW,
  input  wire logic       I2C_SCL_PULL_LOW,
  output logic            I2C_SDA_IN,
  output logic            I2C_SCL_IN,
  // Analog
  output logic      [3:0] ANALOG_ENABLE,
  // Interrupts
  input  wire logic       NMI_PIN,
  input  wire logic [7:0] EXI_ENABLE,
  input  wire logic [7:0] EXI_EDGE_FALL,
  output logic            NMI_REQUEST,
  output logic      [7:0] EXI_REQUEST,
  // Pins
  output logic      [2:0] P2_OUT,
  input  wire logic [3:0] P4_IN,
  output logic      [3:0] P4_OUT,
  output logic      [3:0] P4_OE,
  input  wire logic [7:0] P8_IN,
  output logic      [7:0] P8_OUT,
  output logic      [7:0] P8_OE
);
  localparam logic [1:0] PRI = pin_mux_pkg::ROLE_PRIMARY;
  localparam logic [1:0] SEC = pin_mux_pkg::ROLE_SECONDARY;
  localparam logic [1:0] TER = pin_mux_pkg::ROLE_TERTIARY;

  function automatic logic [1:0] role_of(input logic [15:0] sel, input int idx);
    logic [1:0] r;
    r = sel[idx*2 +: 2];
    if (r == 2'h3) begin
      r = PRI;
    end
    return r;
  endfunction

  // Synchronised pins
  logic [3:0] p4_lvl;
  logic [7:0] p8_lvl;
  logic [7:0] p8_rise;
  logic [7:0] p8_fall;
  logic       nmi_lvl;
  logic       nmi_rise;
  logic       nmi_fall;
  logic       rst_lvl;
  logic       rst_unused_r;
  logic       rst_unused_f;

  pin_edge_sync #(.W(4)) u_p4 (
    .clk(CLK_SYS), .rst(RESET), .pin_in(P4_IN),
    .level(p4_lvl), .rise(), .fall()
  );
  pin_edge_sync #(.W(8)) u_p8 (
    .clk(CLK_SYS), .rst(RESET), .pin_in(P8_IN),
    .level(p8_lvl), .rise(p8_rise), .fall(p8_fall)
  );
  pin_edge_sync #(.W(1)) u_nmi (
    .clk(CLK_SYS), .rst(RESET), .pin_in(NMI_PIN),
    .level(nmi_lvl), .rise(nmi_rise), .fall(nmi_fall)
  );
  pin_edge_sync #(.W(1)) u_rst (
    .clk(CLK_SYS), .rst(RESET), .pin_in(RESET_PIN_N),
    .level(rst_lvl), .rise(rst_unused_r), .fall(rst_unused_f)
  );

  // Role decode per pin
  logic [15:0] p2_sel16;
  logic [15:0] p4_sel16;
  assign p2_sel16 = {10'h000, P2_ROLE_SEL};
  assign p4_sel16 = {8'h00, P4_ROLE_SEL};

  logic [2:0] p2_role_sec;
  logic [3:0] p4_role_sec;
  logic [3:0] p4_role_ter;
  logic [7:0] p8_role_sec;
  logic [7:0] p8_role_ter;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_p2
      assign p2_role_sec[g] = (role_of(p2_sel16, g) == SEC);
    end
    for (g = 0; g < 4; g++) begin : g_p4
      assign p4_role_sec[g] = (role_of(p4_sel16, g) == SEC);
      assign p4_role_ter[g] = (role_of(p4_sel16, g) == TER);
    end
    for (g = 0; g < 8; g++) begin : g_p8
      assign p8_role_sec[g] = (role_of(P8_ROLE_SEL, g) == SEC);
      assign p8_role_ter[g] = (role_of(P8_ROLE_SEL, g) == TER);
    end
  endgenerate

  // Serial channel 0 uses the port 4 set or the port 8 set, both tertiary
  logic s0_on_p4;
  logic s0_on_p8;
  assign s0_on_p4 = ~SERIAL0_PIN_SET;
  assign s0_on_p8 = SERIAL0_PIN_SET;

  // Port 2 output mux, output only
  logic [2:0] p2_pri;
  logic [2:0] p2_nxt;
  assign p2_pri = P2_PORT_OUT | (LED_MODE & LED_DRIVE_OUTPUTS);
  assign p2_nxt[0] = p2_role_sec[0] ? SLOW_CLOCK_OUT : p2_pri[0];
  assign p2_nxt[1] = p2_role_sec[1] ? FAST_CLOCK_OUT : p2_pri[1];
  assign p2_nxt[2] = p2_pri[2];

  // Port 4 output mux
  logic [3:0] p4_out_nxt;
  logic [3:0] p4_oe_nxt;
  logic [3:0] p4_per_out;
  logic [3:0] p4_per_oe;
  logic       p4_ter0;
  logic       p4_ter1;
  logic       p4_ter2;
  assign p4_ter0 = p4_role_ter[0] & s0_on_p4;
  assign p4_ter1 = p4_role_ter[1] & s0_on_p4;
  assign p4_ter2 = p4_role_ter[2] & s0_on_p4;

  assign p4_per_out[0] = 1'b0;
  assign p4_per_oe[0]  = 1'b0;
  assign p4_per_out[1] = p4_ter1 ? SERIAL0_CLOCK_OUT : SERIAL1_CLOCK_OUT;
  assign p4_per_oe[1]  = p4_ter1 ? SERIAL0_CLOCK_MASTER
                                 : (p4_role_sec[1] & SERIAL1_CLOCK_MASTER);
  assign p4_per_out[2] = p4_ter2 ? SERIAL0_DATA_OUT : SERIAL1_DATA_OUT;
  assign p4_per_oe[2]  = p4_ter2 | p4_role_sec[2];
  assign p4_per_out[3] = 1'b0;
  assign p4_per_oe[3]  = 1'b0;

  logic [3:0] p4_is_per;
  assign p4_is_per = {1'b0, p4_ter2 | p4_role_sec[2], p4_ter1 | p4_role_sec[1],
                      p4_ter0 | p4_role_sec[0]};
  assign p4_out_nxt = (p4_is_per & p4_per_out) | (~p4_is_per & P4_PORT_OUT);
  assign p4_oe_nxt  = (p4_is_per & p4_per_oe) | (~p4_is_per & P4_PORT_OE);

  // Analog channels when pin is not routed to a peripheral and not driven as an output
  logic [3:0] ana_nxt;
  assign ana_nxt = ~p4_is_per & ~P4_PORT_OE & {HAS_CH3, 3'b111};

  // Port 8 output mux
  logic [7:0] p8_is_per;
  logic [7:0] p8_per_out;
  logic [7:0] p8_per_oe;
  logic       s0_t0;
  logic       s0_t1;
  logic       s0_t2;
  assign s0_t0 = p8_role_ter[0] & s0_on_p8;
  assign s0_t1 = p8_role_ter[1] & s0_on_p8;
  assign s0_t2 = p8_role_ter[2] & s0_on_p8;

  // Bit 0: I2C data open drain or serial 0 input
  assign p8_per_out[0] = 1'b0;
  assign p8_per_oe[0]  = p8_role_sec[0] & I2C_SDA_PULL_LOW;
  // Bit 1: I2C clock open drain or serial 0 clock
  assign p8_per_out[1] = s0_t1 ? SERIAL0_CLOCK_OUT : 1'b0;
  assign p8_per_oe[1]  = s0_t1 ? SERIAL0_CLOCK_MASTER
                               : (p8_role_sec[1] & I2C_SCL_PULL_LOW);
  // Bit 2: serial 0 data out
  assign p8_per_out[2] = SERIAL0_DATA_OUT;
  assign p8_per_oe[2]  = s0_t2;
  assign p8_per_out[3] = 1'b0;
  assign p8_per_oe[3]  = 1'b0;
  // Bits 4-6: serial 1 tertiary; bit 6 secondary is UART receive
  assign p8_per_out[4] = 1'b0;
  assign p8_per_oe[4]  = 1'b0;
  assign p8_per_out[5] = SERIAL1_CLOCK_OUT;
  assign p8_per_oe[5]  = p8_role_ter[5] & SERIAL1_CLOCK_MASTER;
  assign p8_per_out[6] = SERIAL1_DATA_OUT;
  assign p8_per_oe[6]  = p8_role_ter[6];
  // Bit 7: UART transmit
  assign p8_per_out[7] = UART_TRANSMIT_LINE;
  assign p8_per_oe[7]  = p8_role_sec[7];

  assign p8_is_per = {p8_role_sec[7], p8_role_sec[6] | p8_role_ter[6], p8_role_ter[5],
                      p8_role_ter[4], 1'b0, s0_t2, p8_role_sec[1] | s0_t1,
                      p8_role_sec[0] | s0_t0};

  logic [7:0] p8_out_nxt;
  logic [7:0] p8_oe_nxt;
  assign p8_out_nxt = (p8_is_per & p8_per_out) | (~p8_is_per & P8_PORT_OUT);
  assign p8_oe_nxt  = (p8_is_per & p8_per_oe) | (~p8_is_per & P8_PORT_OE);

  // Peripheral inputs taken from synchronised pins
  logic s0_din_nxt;
  logic s0_ck_nxt;
  logic s1_din_nxt;
  logic s1_ck_nxt;
  assign s0_din_nxt = s0_on_p8 ? p8_lvl[0] : p4_lvl[0];
  assign s0_ck_nxt  = s0_on_p8 ? p8_lvl[1] : p4_lvl[1];
  assign s1_din_nxt = p8_role_ter[4] ? p8_lvl[4] : p4_lvl[0];
  assign s1_ck_nxt  = p8_role_ter[5] ? p8_lvl[5] : p4_lvl[1];

  // External interrupts on port 8, edge chosen per bit
  logic [7:0] exi_nxt;
  assign exi_nxt = EXI_ENABLE & ((EXI_EDGE_FALL & p8_fall) | (~EXI_EDGE_FALL & p8_rise));

  // Registered outputs
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      SYS_RESET         <= 1'b1;
      P2_OUT            <= '0;
      P4_OUT            <= '0;
      P4_OE             <= '0;
      P8_OUT            <= '0;
      P8_OE             <= '0;
      P4_PORT_DATA_REG  <= '0;
      P8_PORT_DATA_REG  <= '0;
      SERIAL0_DATA_IN   <= 1'b0;
      SERIAL0_CLOCK_IN  <= 1'b0;
      SERIAL1_DATA_IN   <= 1'b0;
      SERIAL1_CLOCK_IN  <= 1'b0;
      UART_RECEIVE_LINE <= 1'b1;
      I2C_SDA_IN        <= 1'b1;
      I2C_SCL_IN        <= 1'b1;
      ANALOG_ENABLE     <= '0;
      NMI_REQUEST       <= 1'b0;
      EXI_REQUEST       <= pin_mux_pkg::EXI_EN_RESET;
    end else begin
      SYS_RESET         <= ~rst_lvl;
      P2_OUT            <= p2_nxt;
      P4_OUT            <= p4_out_nxt;
      P4_OE             <= p4_oe_nxt;
      P8_OUT            <= p8_out_nxt;
      P8_OE             <= p8_oe_nxt;
      P4_PORT_DATA_REG  <= p4_lvl;
      P8_PORT_DATA_REG  <= p8_lvl;
      SERIAL0_DATA_IN   <= s0_din_nxt;
      SERIAL0_CLOCK_IN  <= s0_ck_nxt;
      SERIAL1_DATA_IN   <= s1_din_nxt;
      SERIAL1_CLOCK_IN  <= s1_ck_nxt;
      UART_RECEIVE_LINE <= p8_lvl[6];
      I2C_SDA_IN        <= p8_lvl[0];
      I2C_SCL_IN        <= p8_lvl[1];
      ANALOG_ENABLE     <= ana_nxt;
      NMI_REQUEST       <= nmi_rise | nmi_fall;
      EXI_REQUEST       <= exi_nxt;
    end
  end
endmodule

// >>> sim/board_pins.sv
// Purpose: Off-chip circuits on the shared port pins
// Assumes: Device drive wins over board drive
// Notes:   Undriven pins without pull wander
`timescale 1ns/1ps
module board_pins (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [7:0] out8,
  input  wire logic [7:0] oe8,
  input  wire logic [3:0] out4,
  input  wire logic [3:0] oe4,
  // Board drive
  input  wire logic [7:0] drv8,
  input  wire logic [7:0] drv_en8,
  input  wire logic [3:0] drv4,
  // Pin levels
  output logic      [7:0] in8,
  output logic      [3:0] in4
);
  logic [7:0] last_r;
  // Pull-ups on the two-wire pair, elsewhere the last level inverted
  wire logic [7:0] idle8 = {~last_r[7:2], 2'b11};
  // Undriven port 8 pins are pulled up on bits 0-1, elsewhere they take a toggling level
  assign in8 = (oe8 & out8) | (~oe8 & drv_en8 & drv8) | (~oe8 & ~drv_en8 & idle8);
  assign in4 = (oe4 & out4) | (~oe4 & drv4);
  always_ff @(posedge clk) begin
    last_r <= in8;
  end
endmodule

// >>> sim/pin_mux_checker.sv
// Purpose: Port-level assertions for the port function multiplexer
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module after the checker
`timescale 1ns/1ps
module pin_mux_checker (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  // Selectors and sources
  input wire logic [5:0]  P2_ROLE_SEL,
  input wire logic [15:0] P8_ROLE_SEL,
  input wire logic [7:0]  P8_PORT_OUT,
  input wire logic [7:0]  P8_PORT_OE,
  input wire logic        SLOW_CLOCK_OUT,
  input wire logic        FAST_CLOCK_OUT,
  input wire logic        UART_TRANSMIT_LINE,
  input wire logic        I2C_SDA_PULL_LOW,
  input wire logic        I2C_SCL_PULL_LOW,
  input wire logic [7:0]  EXI_ENABLE,
  // Pins
  input wire logic        RESET_PIN_N,
  input wire logic        NMI_PIN,
  input wire logic [7:0]  P8_IN,
  input wire logic [2:0]  P2_OUT,
  input wire logic [7:0]  P8_OUT,
  input wire logic [7:0]  P8_OE,
  // Results
  input wire logic        SYS_RESET,
  input wire logic        NMI_REQUEST,
  input wire logic [7:0]  EXI_REQUEST,
  input wire logic [7:0]  P8_PORT_DATA_REG
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_slow_clk_route: assert property (
    P2_ROLE_SEL[1:0] == pin_mux_pkg::ROLE_SECONDARY |=> P2_OUT[0] == $past(SLOW_CLOCK_OUT))
    else $error("slow clock missing on port 2 bit 0");
  a_fast_clk_route: assert property (
    P2_ROLE_SEL[3:2] == pin_mux_pkg::ROLE_SECONDARY |=> P2_OUT[1] == $past(FAST_CLOCK_OUT))
    else $error("fast clock missing on port 2 bit 1");
  a_uart_tx_route: assert property (
    P8_ROLE_SEL[15:14] == pin_mux_pkg::ROLE_SECONDARY
    |=> P8_OE[7] && P8_OUT[7] == $past(UART_TRANSMIT_LINE))
    else $error("transmit line missing on port 8 bit 7");
  a_sda_open_drain: assert property (
    P8_ROLE_SEL[1:0] == pin_mux_pkg::ROLE_SECONDARY
    |=> !P8_OUT[0] && P8_OE[0] == $past(I2C_SDA_PULL_LOW))
    else $error("data line not open drain");
  a_scl_open_drain: assert property (
    P8_ROLE_SEL[3:2] == pin_mux_pkg::ROLE_SECONDARY
    |=> !P8_OUT[1] && P8_OE[1] == $past(I2C_SCL_PULL_LOW))
    else $error("clock line not open drain");
  a_primary_port: assert property (
    P8_ROLE_SEL[15:14] == pin_mux_pkg::ROLE_PRIMARY |=> P8_OE[7] == $past(P8_PORT_OE[7])
    && (!P8_OE[7] || P8_OUT[7] == $past(P8_PORT_OUT[7])))
    else $error("port role not driving port 8 bit 7");
  a_nmi_both_edges: assert property ($changed(NMI_PIN) |-> ##[1:5] NMI_REQUEST)
    else $error("edge on the non-maskable input gave no request");
  a_exi_masked: assert property (
    (EXI_ENABLE == 8'h00) [*5] |-> EXI_REQUEST == 8'h00)
    else $error("request from a disabled input");
  a_reset_enter: assert property ($fell(RESET_PIN_N) |-> ##[1:4] SYS_RESET)
    else $error("reset pin low without system reset");
  a_reset_leave: assert property ($rose(RESET_PIN_N) |-> ##[1:4] !SYS_RESET)
    else $error("system reset stuck after pin release");
  a_pin_readback: assert property (
    ($stable(P8_IN) && !$past(RESET, 6)) [*5] |-> P8_PORT_DATA_REG == P8_IN)
    else $error("port data does not follow the pins");
  c_nmi: cover property (NMI_REQUEST);
  c_exi: cover property (EXI_REQUEST != 8'h00);
  c_uart: cover property (P8_ROLE_SEL[15:14] == pin_mux_pkg::ROLE_SECONDARY);
endmodule

bind port_function_multiplexer pin_mux_checker pin_mux_checker_inst (.*);

// >>> sim/port_function_multiplexer_tb.sv
// Purpose: Self-checking bench for the port function multiplexer
// Assumes: Board model on ports 4 and 8
// Notes:   Table rows for role routing, hand tests for events
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module port_function_multiplexer_tb;
  typedef struct packed {
    logic [5:0] p2s; logic [7:0] p4s; logic [15:0] p8s; logic ps; logic [2:0] lm;
    logic [2:0] p2o; logic [3:0] p4e; logic [3:0] p4o; logic [7:0] p8e; logic [7:0] p8o;
    logic [3:0] an;
  } row_type;
  row_type rows [9] = '{
    '{6'h00, 8'h00, 16'h0000, 1'b0, 3'h0, 3'h5, 4'h3, 4'h1, 8'hF0, 8'hA0, 4'hC},
    '{6'h05, 8'h00, 16'h0000, 1'b0, 3'h0, 3'h6, 4'h3, 4'h1, 8'hF0, 8'hA0, 4'hC},
    '{6'h00, 8'h00, 16'h5000, 1'b0, 3'h0, 3'h5, 4'h3, 4'h1, 8'hB0, 8'h20, 4'hC},
    '{6'h00, 8'h00, 16'h0005, 1'b0, 3'h0, 3'h5, 4'h3, 4'h1, 8'hF1, 8'hA0, 4'hC},
    '{6'h00, 8'h00, 16'h002A, 1'b1, 3'h0, 3'h5, 4'h3, 4'h1, 8'hF6, 8'hA4, 4'hC},
    '{6'h00, 8'h00, 16'h2A00, 1'b1, 3'h0, 3'h5, 4'h3, 4'h1, 8'hE0, 8'hA0, 4'hC},
    '{6'h00, 8'h2A, 16'h0000, 1'b0, 3'h0, 3'h5, 4'h6, 4'h4, 8'hF0, 8'hA0, 4'h8},
    '{6'h00, 8'h15, 16'h0000, 1'b0, 3'h0, 3'h5, 4'h6, 4'h2, 8'hF0, 8'hA0, 4'h8},
    '{6'h00, 8'h00, 16'h0000, 1'b0, 3'h7, 3'h7, 4'h3, 4'h1, 8'hF0, 8'hA0, 4'hC}};
  logic CLK_SYS = 0, RESET = 1, RESET_PIN_N = 1, NMI_PIN = 0, SERIAL0_PIN_SET = 0;
  logic SLOW_CLOCK_OUT = 0, FAST_CLOCK_OUT = 1, UART_TRANSMIT_LINE = 0;
  logic SERIAL0_DATA_OUT = 1, SERIAL0_CLOCK_OUT = 0, SERIAL0_CLOCK_MASTER = 1;
  logic SERIAL1_DATA_OUT = 0, SERIAL1_CLOCK_OUT = 1, SERIAL1_CLOCK_MASTER = 1;
  logic I2C_SDA_PULL_LOW = 1, I2C_SCL_PULL_LOW = 0;
  logic [5:0] P2_ROLE_SEL = 6'h00;
  logic [7:0] P4_ROLE_SEL = 8'h00, P8_PORT_OUT = 8'hA5, P8_PORT_OE = 8'hF0;
  logic [15:0] P8_ROLE_SEL = 16'h0000;
  logic [2:0] P2_PORT_OUT = 3'h5, LED_DRIVE_OUTPUTS = 3'h2, LED_MODE = 3'h0;
  logic [3:0] P4_PORT_OUT = 4'h5, P4_PORT_OE = 4'h3;
  logic [7:0] EXI_ENABLE = 8'h00, EXI_EDGE_FALL = 8'h00, drv8 = 8'h1B, acc;
  logic SYS_RESET, SERIAL0_DATA_IN, SERIAL0_CLOCK_IN, SERIAL1_DATA_IN, SERIAL1_CLOCK_IN;
  logic UART_RECEIVE_LINE, I2C_SDA_IN, I2C_SCL_IN, NMI_REQUEST;
  logic [2:0] P2_OUT;
  logic [3:0] P4_PORT_DATA_REG, ANALOG_ENABLE, P4_IN, P4_OUT, P4_OE;
  logic [7:0] P8_PORT_DATA_REG, EXI_REQUEST, P8_IN, P8_OUT, P8_OE;
  int err_count = 0, n_checks = 0, np;
  port_function_multiplexer port_function_multiplexer_inst (.*);
  board_pins board_pins_inst (.clk(CLK_SYS), .out8(P8_OUT), .oe8(P8_OE), .out4(P4_OUT),
    .oe4(P4_OE), .drv8(drv8), .drv_en8(8'hFC), .drv4(4'hA), .in8(P8_IN), .in4(P4_IN));
  always #20 CLK_SYS = ~CLK_SYS;
  task automatic conclude();
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic watch(input int n);
    acc = 8'h00;
    np = 0;
    repeat (n) begin
      @(posedge CLK_SYS);
      #1;
      acc |= EXI_REQUEST;
      np += NMI_REQUEST;
    end
  endtask
  initial begin
    #(40 * 3000);
    err_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge CLK_SYS);
    #1;
    `CHK(P8_OE, 8'h00)
    @(posedge CLK_SYS);
    RESET <= 0;
    for (int i = 0; i < 9; i++) begin
      @(posedge CLK_SYS);
      P2_ROLE_SEL <= rows[i].p2s;
      P4_ROLE_SEL <= rows[i].p4s;
      P8_ROLE_SEL <= rows[i].p8s;
      SERIAL0_PIN_SET <= rows[i].ps;
      LED_MODE <= rows[i].lm;
      repeat (6) @(posedge CLK_SYS);
      #1;
      `CHK(P2_OUT, rows[i].p2o)
      `CHK(P4_OE, rows[i].p4e)
      `CHK(P4_OUT & P4_OE, rows[i].p4o)
      `CHK(P8_OE, rows[i].p8e)
      `CHK(P8_OUT & P8_OE, rows[i].p8o)
      `CHK(ANALOG_ENABLE, rows[i].an)
      `CHK(P8_PORT_DATA_REG, rows[i].p8o | (~rows[i].p8e & 8'h1B))
      `CHK(P4_PORT_DATA_REG, rows[i].p4o | (~rows[i].p4e & 4'hA))
      if (i == 2) `CHK(UART_RECEIVE_LINE, 1'b0)
      if (i == 3) `CHK(I2C_SDA_IN, 1'b0)
      if (i == 3) `CHK(I2C_SCL_IN, 1'b1)
      if (i == 4) `CHK(SERIAL0_CLOCK_IN, 1'b0)
      if (i == 5) `CHK(SERIAL1_CLOCK_IN, 1'b1)
      if (i == 6) `CHK(SERIAL0_DATA_IN, 1'b0)
      if (i == 7) `CHK(SERIAL1_DATA_IN, 1'b0)
    end
    @(posedge CLK_SYS);
    EXI_ENABLE <= 8'h0C;
    EXI_EDGE_FALL <= 8'h08;
    watch(8);
    @(posedge CLK_SYS);
    drv8 <= 8'h17;
    NMI_PIN <= 1;
    watch(10);
    `CHK(acc, 8'h0C)
    `CHK(np, 1)
    @(posedge CLK_SYS);
    drv8 <= 8'h1B;
    NMI_PIN <= 0;
    watch(10);
    `CHK(acc, 8'h00)
    `CHK(np, 1)
    @(posedge CLK_SYS);
    EXI_ENABLE <= 8'h00;
    drv8 <= 8'h17;
    watch(10);
    `CHK(acc, 8'h00)
    @(posedge CLK_SYS);
    RESET_PIN_N <= 0;
    watch(6);
    `CHK(SYS_RESET, 1'b1)
    @(posedge CLK_SYS);
    RESET_PIN_N <= 1;
    watch(6);
    `CHK(SYS_RESET, 1'b0)
    conclude();
  end
endmodule
